/* File: verilog/fae_host.sv */
// Contract
// - Depth cascade holds 63n+1 four-bit words.
// - Side-by-side slices give 64 words, 4n bits.
// - Most significant slice drives all push strobes; here the write sequencer drives them.
// - MSB valid flag drives every serial unload.
// - m-by-n array stores 63m+1 words, 4n wide.
// - Write on last full_n high; read on valid.
// - Row master serial enable tied low; slaves chained.
`timescale 1ns/1ps
module fae_host (
  input wire logic clk, // System clock, 125 MHz.
  input wire logic reset, // Synchronous reset, active high.
  input wire logic in_valid, // Upstream word offered.
  input wire logic [fae_pkg::WORD_W-1:0] in_data, // Upstream word.
  output logic in_ready, // Write buffer has room.
  output logic out_valid, // Extracted word held for downstream.
  output logic [fae_pkg::WORD_W-1:0] out_data, // Extracted word.
  input wire logic out_ready, // Downstream takes the word.
  output logic master_clear_n, // Clear to all slices, active low.
  output logic serial_in_enable_n, // Enable for the row master, held low.
  output fae_pkg::fae_in_ctl_t in_ctl, // Load and push strobes to the top row.
  output logic [fae_pkg::WORD_W-1:0] array_data, // Parallel data to the top row.
  input wire logic input_full_n, // Full flag of the last slave, top row.
  output logic parallel_unload, // Parallel unload strobe to the bottom row.
  output logic serial_unload_n, // Serial unload strobe to the bottom row.
  input wire logic output_valid_last, // Valid flag of the last slave, bottom row.
  input wire logic output_valid_msb, // Valid flag of the most significant slice.
  input wire logic [fae_pkg::WORD_W-1:0] array_q // Parallel data from the bottom row.
);

  localparam int SYNC_W = fae_pkg::WORD_W + 3;

  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic [SYNC_W-1:0] sync_rst;
  logic full_n_s;
  logic valid_last_s;
  logic valid_msb_s;
  logic [fae_pkg::WORD_W-1:0] q_s;

  // Every pin from the array crosses two flops; the first stage feeds only the second.
  assign sync_rst = {fae_pkg::SYNC_FULL_N_RST, fae_pkg::SYNC_VALID_RST, fae_pkg::SYNC_VALID_RST,
                     {fae_pkg::WORD_W{1'b0}}};
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_reg <= sync_rst;
      sync2_reg <= sync_rst;
    end else begin
      sync1_reg <= {input_full_n, output_valid_last, output_valid_msb, array_q};
      sync2_reg <= sync1_reg;
    end
  end
  assign {full_n_s, valid_last_s, valid_msb_s, q_s} = sync2_reg;

  // Write buffer state.
  logic [fae_pkg::WORD_W-1:0] mem_reg [fae_pkg::BUF_DEPTH];
  logic [fae_pkg::WORD_W-1:0] mem_next [fae_pkg::BUF_DEPTH];
  logic wptr_reg;
  logic wptr_next;
  logic rptr_reg;
  logic rptr_next;
  logic [1:0] count_reg;
  logic [1:0] count_next;
  logic in_ready_reg;
  logic in_ready_next;
  logic buf_push;
  logic buf_pop;

  // Write sequencer state.
  fae_pkg::fae_wr_state_t wr_reg;
  fae_pkg::fae_wr_state_t wr_next;
  logic [3:0] clr_cnt_reg;
  logic [3:0] clr_cnt_next;
  logic master_clear_n_reg;
  logic master_clear_n_next;
  fae_pkg::fae_in_ctl_t in_ctl_reg;
  fae_pkg::fae_in_ctl_t in_ctl_next;
  logic [fae_pkg::WORD_W-1:0] array_data_reg;
  logic [fae_pkg::WORD_W-1:0] array_data_next;

  // Read sequencer state.
  fae_pkg::fae_rd_state_t rd_reg;
  fae_pkg::fae_rd_state_t rd_next;
  logic parallel_unload_reg;
  logic parallel_unload_next;
  logic serial_unload_n_reg;
  logic serial_unload_n_next;
  logic serial_in_enable_n_reg;
  logic out_valid_reg;
  logic out_valid_next;
  logic [fae_pkg::WORD_W-1:0] out_data_reg;
  logic [fae_pkg::WORD_W-1:0] out_data_next;

  // Buffer next state; ready is registered from the next count so it never overpromises.
  always_comb begin
    buf_push = in_valid && in_ready_reg;
    mem_next = mem_reg;
    wptr_next = wptr_reg;
    rptr_next = rptr_reg;
    count_next = count_reg;
    if (buf_push) begin
      mem_next[wptr_reg] = in_data;
      wptr_next = ~wptr_reg;
    end
    if (buf_pop) begin
      rptr_next = ~rptr_reg;
    end
    if (buf_push && !buf_pop) begin
      count_next = count_reg + 2'h1;
    end else if (buf_pop && !buf_push) begin
      count_next = count_reg - 2'h1;
    end
    in_ready_next = (count_next != fae_pkg::BUF_FULL_COUNT);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wptr_reg <= 1'b0;
      rptr_reg <= 1'b0;
      count_reg <= fae_pkg::BUF_EMPTY_COUNT;
      in_ready_reg <= 1'b0;
    end else begin
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      count_reg <= count_next;
      in_ready_reg <= in_ready_next;
    end
  end

  // Storage needs no reset; only entries pushed since reset are ever read.
  always_ff @(posedge clk) begin
    mem_reg <= mem_next;
  end

  // Write sequencer: clear the array, then load a word and push it down.
  // Load is dropped in the same cycle the push goes low, because slices defer
  // their reinit until load is low and would otherwise stall the ripple.
  always_comb begin
    wr_next = wr_reg;
    clr_cnt_next = clr_cnt_reg;
    master_clear_n_next = master_clear_n_reg;
    in_ctl_next = in_ctl_reg;
    array_data_next = array_data_reg;
    buf_pop = 1'b0;
    case (wr_reg)
      fae_pkg::WR_CLEAR: begin
        if (clr_cnt_reg == fae_pkg::CLEAR_ZERO) begin
          master_clear_n_next = 1'b1;
          wr_next = fae_pkg::WR_IDLE;
        end else begin
          clr_cnt_next = clr_cnt_reg - 4'h1;
        end
      end
      fae_pkg::WR_IDLE: begin
        if ((count_reg != fae_pkg::BUF_EMPTY_COUNT) && full_n_s) begin
          array_data_next = mem_reg[rptr_reg];
          in_ctl_next.parallel_word_load = 1'b1;
          buf_pop = 1'b1;
          wr_next = fae_pkg::WR_LOAD;
        end
      end
      fae_pkg::WR_LOAD: begin
        if (!full_n_s) begin
          in_ctl_next.parallel_word_load = 1'b0;
          in_ctl_next.stack_push_n = 1'b0;
          wr_next = fae_pkg::WR_PUSH;
        end
      end
      fae_pkg::WR_PUSH: begin
        // The last slave's flag rises only after the reinit has rippled along the row.
        if (full_n_s) begin
          in_ctl_next.stack_push_n = 1'b1;
          wr_next = fae_pkg::WR_IDLE;
        end
      end
      default: begin
        wr_next = fae_pkg::WR_CLEAR;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_reg <= fae_pkg::WR_CLEAR;
      clr_cnt_reg <= fae_pkg::CLEAR_LAST;
      master_clear_n_reg <= 1'b0;
      in_ctl_reg <= fae_pkg::IN_CTL_RST;
      array_data_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      clr_cnt_reg <= clr_cnt_next;
      master_clear_n_reg <= master_clear_n_next;
      in_ctl_reg <= in_ctl_next;
      array_data_reg <= array_data_next;
    end
  end

  // Read sequencer: take a word once the last slave is valid, then drop the
  // unload strobe until the flag falls. A stalled consumer simply leaves the
  // word in the array. Data and flag share the same sync depth; the slice
  // presents data before its flag rises, so the captured word is settled.
  always_comb begin
    rd_next = rd_reg;
    parallel_unload_next = parallel_unload_reg;
    out_valid_next = out_valid_reg;
    out_data_next = out_data_reg;
    serial_unload_n_next = valid_msb_s;
    if (out_valid_reg && out_ready) begin
      out_valid_next = 1'b0;
    end
    case (rd_reg)
      fae_pkg::RD_HOLD: begin
        if (master_clear_n_reg) begin
          parallel_unload_next = 1'b1;
          rd_next = fae_pkg::RD_WAIT;
        end
      end
      fae_pkg::RD_WAIT: begin
        if (valid_last_s && !out_valid_reg) begin
          out_data_next = q_s;
          out_valid_next = 1'b1;
          parallel_unload_next = 1'b0;
          rd_next = fae_pkg::RD_DRAIN;
        end
      end
      fae_pkg::RD_DRAIN: begin
        if (!valid_last_s) begin
          parallel_unload_next = 1'b1;
          rd_next = fae_pkg::RD_WAIT;
        end
      end
      default: begin
        rd_next = fae_pkg::RD_HOLD;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_reg <= fae_pkg::RD_HOLD;
      parallel_unload_reg <= 1'b0;
      serial_unload_n_reg <= 1'b0;
      out_valid_reg <= 1'b0;
      out_data_reg <= '0;
      serial_in_enable_n_reg <= 1'b0;
    end else begin
      rd_reg <= rd_next;
      parallel_unload_reg <= parallel_unload_next;
      serial_unload_n_reg <= serial_unload_n_next;
      out_valid_reg <= out_valid_next;
      out_data_reg <= out_data_next;
      serial_in_enable_n_reg <= 1'b0;
    end
  end

  assign in_ready = in_ready_reg;
  assign out_valid = out_valid_reg;
  assign out_data = out_data_reg;
  assign master_clear_n = master_clear_n_reg;
  assign serial_in_enable_n = serial_in_enable_n_reg;
  assign in_ctl = in_ctl_reg;
  assign array_data = array_data_reg;
  assign parallel_unload = parallel_unload_reg;
  assign serial_unload_n = serial_unload_n_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // A push begins right after a completed load.
  sequence s_load_done;
    in_ctl_reg.parallel_word_load ##1 !in_ctl_reg.parallel_word_load;
  endsequence

  AST_LOAD_ON_FREE: assert property ($rose(in_ctl_reg.parallel_word_load) |-> $past(full_n_s))
    else $error("Load issued while last slave was still full.");

  AST_PUSH_AFTER_LOAD: assert property (s_load_done |-> !in_ctl_reg.stack_push_n)
    else $error("Push did not follow the end of a load.");

  AST_PUSH_HOLD: assert property ((!in_ctl_reg.stack_push_n && !full_n_s) |=>
    (!in_ctl_reg.stack_push_n && !in_ctl_reg.parallel_word_load))
    else $error("Push released before the row reported empty.");

  AST_TAKE_ON_VALID: assert property ($fell(parallel_unload_reg) |->
    ($past(valid_last_s) && out_valid_reg))
    else $error("Word taken without a valid flag from the last slave.");

  AST_UNLOAD_FOLLOWS_MSB: assert property (##1 serial_unload_n_reg == $past(valid_msb_s))
    else $error("Serial unload does not follow the most significant valid flag.");

  AST_MASTER_ENABLE_LOW: assert property (##1 !serial_in_enable_n_reg)
    else $error("Row master serial enable left high.");

endmodule : fae_host

/* File: verilog/fae_pkg.sv */
package fae_pkg;

  // Array geometry: slices per row set the word width, four bits per slice.
  localparam int SLICE_W = 4;
  localparam int ROW_SLICES = 3;
  localparam int WORD_W = SLICE_W * ROW_SLICES;

  // Two-entry buffer in the write path.
  localparam int BUF_DEPTH = 2;
  localparam logic [1:0] BUF_FULL_COUNT = 2'h2;
  localparam logic [1:0] BUF_EMPTY_COUNT = 2'h0;

  // Clock rate and the width of the master clear pulse sent after reset.
  localparam int CLK_MHZ = 125;
  localparam int CLEAR_NS = 100;
  localparam int CLEAR_CYC = (CLEAR_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] CLEAR_LAST = 4'(CLEAR_CYC - 1);
  localparam logic [3:0] CLEAR_ZERO = 4'h0;

  // Synchroniser reset values: pins idle as after a master clear.
  localparam logic SYNC_FULL_N_RST = 1'h1;
  localparam logic SYNC_VALID_RST = 1'h0;

  // Write side sequencer states.
  typedef enum logic [1:0] {
    WR_CLEAR = 2'b00,
    WR_IDLE = 2'b01,
    WR_LOAD = 2'b10,
    WR_PUSH = 2'b11
  } fae_wr_state_t;

  // Read side sequencer states.
  typedef enum logic [1:0] {
    RD_HOLD = 2'b00,
    RD_WAIT = 2'b01,
    RD_DRAIN = 2'b10
  } fae_rd_state_t;

  // Input strobes that go to every slice of the top row together.
  typedef struct packed {
    logic parallel_word_load;
    logic stack_push_n;
  } fae_in_ctl_t;

  localparam fae_in_ctl_t IN_CTL_RST = '{parallel_word_load: 1'h0, stack_push_n: 1'h1};

endpackage : fae_pkg

/* File: testbench/fae_array_model.sv */
`timescale 1ns/1ps
module fae_array_model #(
  parameter int ROWS = 1 // Slices per column of the array.
) (
  input wire logic master_clear_n, // Clear to all slices, active low.
  input wire logic serial_in_enable_n, // Row master enable.
  input wire fae_pkg::fae_in_ctl_t in_ctl, // Load and push strobes.
  input wire logic [fae_pkg::WORD_W-1:0] array_data, // Parallel data in.
  output logic input_full_n, // Full flag of the last slave.
  input wire logic parallel_unload, // Unload strobe.
  input wire logic serial_unload_n, // Serial unload strobe, not used here.
  output logic output_valid_last, // Valid flag of the last slave.
  output logic output_valid_msb, // Valid flag of the most significant slice.
  output logic [fae_pkg::WORD_W-1:0] array_q, // Parallel data out.
  input wire logic slow // Stretches every internal delay.
);
  localparam int CAP = 63 * ROWS + 1;
  logic [fae_pkg::WORD_W-1:0] stack[$];
  logic in_full;
  logic out_full;
  logic master_latch;
  int lag;

  // One loop, stepped off the clock grid, so flags change asynchronously to the host.
  initial begin
    input_full_n = 1'h1;
    output_valid_last = 1'h0;
    output_valid_msb = 1'h0;
    array_q = '0;
    in_full = 1'h0;
    out_full = 1'h0;
    master_latch = 1'h0;
    #0.5;
    forever begin
      #1;
      lag = (slow === 1'b1) ? 30 : 1;
      if (master_clear_n !== 1'b1) begin
        stack.delete();
        in_full = 1'h0;
        out_full = 1'h0;
        input_full_n = 1'h1;
        output_valid_msb = 1'h0;
        output_valid_last = 1'h0;
        master_latch = (serial_in_enable_n === 1'b0);
      end else begin
        if (in_ctl.parallel_word_load === 1'b1 && !in_full) begin
          in_full = 1'h1;
          stack.push_back(array_data);
          #(lag) input_full_n = 1'h0;
        end
        // Push waits for load low and for the enable chain to ripple down the row.
        if (in_ctl.stack_push_n === 1'b0 && in_full && in_ctl.parallel_word_load === 1'b0 &&
            stack.size() <= CAP - 2 && (master_latch || serial_in_enable_n === 1'b0)) begin
          in_full = 1'h0;
          #(lag * fae_pkg::ROW_SLICES) input_full_n = 1'h1;
        end
        if (parallel_unload === 1'b1 && !out_full && stack.size() > (in_full ? 1 : 0)) begin
          out_full = 1'h1;
          array_q = stack.pop_front();
          #(lag) output_valid_msb = master_latch;
          #(lag * fae_pkg::ROW_SLICES) output_valid_last = 1'h1;
        end
        if (parallel_unload === 1'b0 && out_full) begin
          out_full = 1'h0;
          #(lag) output_valid_msb = 1'h0;
          #(lag) output_valid_last = 1'h0;
        end
      end
    end
  end
endmodule : fae_array_model

/* File: testbench/fifo_array_expansion_interlock_bench.sv */
`timescale 1ns/1ps
module fifo_array_expansion_interlock_bench;
  localparam int W = fae_pkg::WORD_W;
  localparam int CAP = 63 * 1 + 1;
  logic clk;
  logic reset;
  logic in_valid;
  logic [W-1:0] in_data;
  logic in_ready;
  logic out_valid;
  logic [W-1:0] out_data;
  logic out_ready;
  logic master_clear_n;
  logic serial_in_enable_n;
  fae_pkg::fae_in_ctl_t in_ctl;
  logic [W-1:0] array_data;
  logic input_full_n;
  logic parallel_unload;
  logic serial_unload_n;
  logic output_valid_last;
  logic output_valid_msb;
  logic [W-1:0] array_q;
  logic slow;
  int num_errors;
  int tests_run;
  logic [W-1:0] sent[$];
  logic [W-1:0] got[$];

  fae_host dut (.clk(clk), .reset(reset), .in_valid(in_valid), .in_data(in_data),
    .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready),
    .master_clear_n(master_clear_n), .serial_in_enable_n(serial_in_enable_n), .in_ctl(in_ctl),
    .array_data(array_data), .input_full_n(input_full_n), .parallel_unload(parallel_unload),
    .serial_unload_n(serial_unload_n), .output_valid_last(output_valid_last),
    .output_valid_msb(output_valid_msb), .array_q(array_q));

  fae_array_model #(.ROWS(1)) array (.master_clear_n(master_clear_n),
    .serial_in_enable_n(serial_in_enable_n), .in_ctl(in_ctl), .array_data(array_data),
    .input_full_n(input_full_n), .parallel_unload(parallel_unload),
    .serial_unload_n(serial_unload_n), .output_valid_last(output_valid_last),
    .output_valid_msb(output_valid_msb), .array_q(array_q), .slow(slow));

  // Free running 125 MHz clock.
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  // Words handed downstream are recorded at the edge that takes them.
  always @(posedge clk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) got.push_back(out_data);
  end

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  // Reset for three cycles, then measure how long the array clear is held.
  task do_reset;
    int cnt;
    cnt = 0;
    reset <= 1'h1;
    repeat (3) @(posedge clk);
    check("clear_in_reset", master_clear_n, 0);
    reset <= 1'h0;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      if (master_clear_n !== 1'b0) break;
      cnt++;
    end
    check("clear_len", cnt >= fae_pkg::CLEAR_CYC && cnt <= fae_pkg::CLEAR_CYC + 2, 1);
    check("row_enable", serial_in_enable_n, 0);
    // Return on a rising edge so that callers drive inputs there.
    @(posedge clk);
  endtask : do_reset

  // Offers n words back to back; stops quietly when one is refused for bound cycles.
  task send(input int n, input int bound, output int took);
    logic [W-1:0] w;
    int t;
    logic ok;
    took = 0;
    for (int k = 0; k < n; k++) begin
      w = W'(sent.size() * 37 + 32'h11);
      in_data <= w;
      in_valid <= 1'h1;
      t = 0;
      do begin
        @(negedge clk);
        t++;
      end while (in_ready !== 1'b1 && t < bound);
      // Judge acceptance before the edge, as the design does; a late ready still counts.
      ok = (in_ready === 1'b1);
      @(posedge clk);
      if (!ok) break;
      sent.push_back(w);
      took++;
    end
    in_valid <= 1'h0;
  endtask : send

  // Waits for every sent word, letting the reader stall one cycle in three.
  task drain(input logic stall);
    for (int i = 0; got.size() < sent.size(); i++) begin
      @(posedge clk);
      out_ready <= !(stall && (i % 3 == 0));
      if (i > 20000) begin
        num_errors++;
        $display("BAD drain timeout");
        tally_and_finish();
      end
    end
    // Let the reader run on, so that a duplicated or stray word shows in the count.
    out_ready <= 1'h1;
    repeat (60) @(posedge clk);
    check("count", got.size(), sent.size());
    foreach (sent[i]) check("word", got[i], sent[i]);
  endtask : drain

  task t_stream;
    int took;
    sent.delete();
    got.delete();
    out_ready <= 1'h1;
    slow <= 1'h0;
    send(8, 200, took);
    check("stream_took", took, 8);
    drain(1'h0);
    $display("stream test done");
  endtask : t_stream

  // Reader stalls until the array refuses; depth counts array, buffer and output word.
  task t_fill_drain;
    int took;
    sent.delete();
    got.delete();
    out_ready <= 1'h0;
    send(80, 300, took);
    check("fill_took", took, CAP + fae_pkg::BUF_DEPTH + 1);
    check("in_ready_full", in_ready, 0);
    check("serial_unload", serial_unload_n, output_valid_msb);
    slow <= 1'h1;
    drain(1'h1);
    slow <= 1'h0;
    $display("fill and drain test done");
  endtask : t_fill_drain

  // A second reset in mid-run discards held words; new traffic flows cleanly.
  task t_reclear;
    int took;
    sent.delete();
    out_ready <= 1'h0;
    send(3, 200, took);
    do_reset();
    check("out_valid_clr", out_valid, 0);
    check("full_n_clr", input_full_n, 1);
    sent.delete();
    got.delete();
    out_ready <= 1'h1;
    send(4, 200, took);
    drain(1'h0);
    $display("reclear test done");
  endtask : t_reclear

  initial begin
    num_errors = 0;
    tests_run = 0;
    reset = 1'h1;
    in_valid = 1'h0;
    in_data = '0;
    out_ready = 1'h0;
    slow = 1'h0;
    do_reset();
    t_stream();
    t_fill_drain();
    t_reclear();
    tally_and_finish();
  end
endmodule : fifo_array_expansion_interlock_bench
